// [pkg/flash_seq_map.svh]
/*
  Constants of the program command sequencer: register offsets, status field
  positions, reset values, command codes and timing counts.
  Assumes it is included by bare name wherever these are needed.
*/
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define REG_STATUS_OFS     8'h00
`define REG_CONTROL_OFS    8'h04
`define REG_COMMAND_OFS    8'h08

// ****************************************
// field positions and reset values
// ****************************************
`define SR_READY_BIT       7
`define SR_ERASE_SUSP_BIT  6
`define SR_PGM_FAIL_BIT    4
`define SR_BUF_ABORT_BIT   3
`define SR_SUSPENDED_BIT   2
`define SR_LOCKED_BIT      1
`define CTL_ECC2_BIT       0
`define CTL_OVL_LSB        1
`define CMD_CLEAR_BIT      0
`define CONTROL_RESET      8'h00

// ****************************************
// command codes and addresses
// ****************************************
`define UNLOCK1_ADDR       12'h555
`define UNLOCK2_ADDR       12'h2AA
`define UNLOCK1_DATA       8'hAA
`define UNLOCK2_DATA       8'h55
`define BUF_LOAD_CODE      16'h0025
`define BUF_CONFIRM_CODE   16'h0029
`define BUF_COUNT_MAX      16'h00FF
`define ERASED_WORD        16'hFFFF

// ****************************************
// link framing and timing
// ****************************************
`define CA_BYTES           3'h6
`define CLK_MHZ            250
`define RECOVERY_NS        1000

`endif

// [pkg/flash_seq_pkg.sv]
/*
  Types of the program command sequencer: controller states, address
  overlays, decoded link words and the registered state apart from ready_o and the buffer memory.
  Assumes a 32-bit word address on the link.
*/
package flash_seq_pkg;

  typedef enum logic [9:0] {
    ST_IDLE        = 10'h001,
    ST_UNLOCK1     = 10'h002,
    ST_UNLOCK2     = 10'h004,
    ST_WP_SETUP    = 10'h008,
    ST_BUF_COUNT   = 10'h010,
    ST_BUF_LOAD    = 10'h020,
    ST_BUF_CONFIRM = 10'h040,
    ST_BUSY        = 10'h080,
    ST_SUSPENDED   = 10'h100,
    ST_RECOVER     = 10'h200
  } ctl_state_type;

  typedef enum logic [1:0] {
    OV_MAIN     = 2'h0,
    OV_SECURE   = 2'h1,
    OV_PROTCFG  = 2'h2,
    OV_VOLATILE = 2'h3
  } address_overlay_type;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic [15:0] data;
  } link_word_type;

  typedef struct packed {
    logic [2:0]  ck_sync;
    logic [1:0]  cs_sync;
    logic [15:0] dq_sync;
    logic [1:0]  rst_sync;
    logic        in_frame;
    logic [2:0]  ca_cnt;
    logic [47:0] ca;
    logic        hi_phase;
    logic [7:0]  hi_byte;
    logic [31:0] link_addr;
    logic        is_read;
    link_word_type word;
    logic        burst_end;
    ctl_state_type state;
    address_overlay_type overlay;
    logic        ecc2_en;
    logic [14:0] sector;
    logic [23:0] line;
    logic [31:0] start_addr;
    logic [8:0]  wp_cnt;
    logic [7:0]  left;
    logic        first;
    logic [255:0] loaded;
    logic [11:0] recover_cnt;
    logic        erase_ret;
    logic        pgm_fail;
    logic        buf_abort;
    logic        locked_fail;
    logic        start;
    logic        suspend;
    logic        resume;
    logic        abort;
    logic        volatile_op;
    logic [7:0]  count;
    logic        ecc_off;
    logic [15:0] rd_data;
    logic        ack;
    logic [31:0] wb_rdata;
  } seq_state_type;

endpackage : flash_seq_pkg

// [rtl/flash_program_command_sequencer.sv]
/*
  Program command sequencer of a flash embedded algorithm controller:
  decodes command writes from the DDR serial link, runs word, burst word and
  buffer programming sequences, keeps the program buffer and status.
  Assumes the link pins are asynchronous to clk_i and slow enough (4 clk_i
  cycles per half link period) to be oversampled; the programming engine and
  the Wishbone slave run on clk_i.
*/
// Implementation choices: the Wishbone slave port and the register offsets.
// Overview of operation
// - reprogramming a programmed half-page disables its ECC.
// - with 2-bit ECC on, reprogramming a page is a program error.
// - word program needs two unlocks, set-up, then address and data.
// - after a word program the controller returns to standby by itself.
// - burst word program loads up to 256 sequential words in one line.
// - while programming, only suspend and status read are obeyed.
// - hardware reset aborts programming, read mode after recovery time.
// - word program in secure overlay; no-unlock variant in protection overlays.
// - program buffer reads all ones at each operation start.
// - buffer program only in main array or secure overlay.
// - unlock AAh at 555h, 55h at 2AAh, then 0025h at sector.
// - word count at same sector, else abort.
// - buffer program to a protected sector fails with status.
// - loading counts words down, every write is data.
// - load outside the line aborts and sets buffer abort bit.
// - confirm 0029h at sector starts programming; anything else aborts.
// - a word count above 255 aborts.
// - aborts set fail and abort bits; cleared by success or clear.
// - buffer program suspendable in main overlay only; completion returns to the prior standby.
`timescale 1ns/10ps
`include "flash_seq_map.svh"

module flash_program_command_sequencer #(
  parameter logic [15:0] WORD_PGM_CODE = 16'h00A0,
  parameter logic [15:0] SUSPEND_CODE  = 16'h00B0,
  parameter logic [15:0] RESUME_CODE   = 16'h0030,
  parameter int          RECOVERY_NS   = `RECOVERY_NS
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ck_i,
  input  wire logic        cs_n_i,
  input  wire logic [7:0]  dq_i,
  input  wire logic        reset_n_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sector_protected_i,
  input  wire logic        erase_suspended_i,
  input  wire logic        pgm_done_i,
  input  wire logic        pgm_fail_i,
  input  wire logic        half_page_written_i,
  input  wire logic [7:0]  buf_rd_idx_i,
  output logic      [15:0] buf_rd_data_o,
  output logic      [14:0] sector_query_o,
  output logic             pgm_start_o,
  output logic             pgm_suspend_o,
  output logic             pgm_resume_o,
  output logic             pgm_abort_o,
  output logic             pgm_volatile_o,
  output logic      [31:0] pgm_addr_o,
  output logic      [7:0]  pgm_count_o,
  output logic             ecc_disable_o,
  output logic             ready_o
);

  // least time rounds up to whole cycles
  localparam int RECOVERY_CYC = (RECOVERY_NS * `CLK_MHZ + 999) / 1000;
  localparam logic [11:0] RECOVERY_LOAD = 12'(RECOVERY_CYC);

  flash_seq_pkg::seq_state_type q;
  flash_seq_pkg::seq_state_type d;
  logic [15:0] buf_mem [256];

  // ****************************************
  // combinational helpers
  // ****************************************
  logic        ck_edge;
  logic        wb_req;
  logic        wv;
  logic [31:0] wa;
  logic [15:0] wd;
  logic        sec_match;
  logic        buf_we;
  logic        busy_like;

  assign ck_edge   = q.ck_sync[1] ^ q.ck_sync[2];
  assign wb_req    = wb_cyc_i & wb_stb_i & ~q.ack;
  assign wv        = q.word.valid;
  assign wa        = q.word.addr;
  assign wd        = q.word.data;
  assign sec_match = (wa[31:17] == q.sector);
  assign busy_like = (q.state == flash_seq_pkg::ST_BUSY) ||
                     (q.state == flash_seq_pkg::ST_SUSPENDED);
  // buffer is written while loading words of either method
  assign buf_we    = wv && ((q.state == flash_seq_pkg::ST_WP_SETUP) ||
                            (q.state == flash_seq_pkg::ST_BUF_LOAD));

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d = q;
    d.start     = 1'b0;
    d.suspend   = 1'b0;
    d.resume    = 1'b0;
    d.abort     = 1'b0;
    d.ecc_off   = 1'b0;
    d.burst_end = 1'b0;
    d.word.valid = 1'b0;

    // pin synchronisers: stage 0 feeds stage 1 only
    d.ck_sync  = {q.ck_sync[1:0], ck_i};
    d.cs_sync  = {q.cs_sync[0], cs_n_i};
    d.dq_sync  = {q.dq_sync[7:0], dq_i};
    d.rst_sync = {q.rst_sync[0], reset_n_i};

    // link framing: six command-address bytes, then data byte pairs
    if (q.cs_sync[1]) begin
      d.in_frame = 1'b0;
      d.ca_cnt   = 3'h0;
      d.hi_phase = 1'b0;
      d.burst_end = q.in_frame;
    end else begin
      d.in_frame = 1'b1;
      if (ck_edge) begin
        if (q.ca_cnt != `CA_BYTES) begin
          d.ca     = {q.ca[39:0], q.dq_sync[15:8]};
          d.ca_cnt = q.ca_cnt + 3'h1;
          if (q.ca_cnt == 3'h5) begin
            d.link_addr = {q.ca[36:8], q.dq_sync[10:8]};
            d.is_read   = q.ca[39];
          end
        end else if (!q.hi_phase) begin
          d.hi_byte  = q.dq_sync[15:8];
          d.hi_phase = 1'b1;
        end else begin
          d.hi_phase   = 1'b0;
          d.word.valid = ~q.is_read;
          d.word.addr  = q.link_addr;
          d.word.data  = {q.hi_byte, q.dq_sync[15:8]};
          d.link_addr  = q.link_addr + 32'h1;
        end
      end
    end

    // Wishbone slave: one wait state, unmapped reads give zero
    d.ack = wb_req;
    if (wb_req) begin
      d.wb_rdata = 32'h0;
      case (wb_adr_i)
        `REG_STATUS_OFS: begin
          d.wb_rdata[`SR_READY_BIT]      = ready_o;
          d.wb_rdata[`SR_ERASE_SUSP_BIT] = q.erase_ret;
          d.wb_rdata[`SR_PGM_FAIL_BIT]   = q.pgm_fail;
          d.wb_rdata[`SR_BUF_ABORT_BIT]  = q.buf_abort;
          d.wb_rdata[`SR_SUSPENDED_BIT]  = (q.state == flash_seq_pkg::ST_SUSPENDED);
          d.wb_rdata[`SR_LOCKED_BIT]     = q.locked_fail;
        end
        `REG_CONTROL_OFS: begin
          d.wb_rdata[`CTL_ECC2_BIT] = q.ecc2_en;
          d.wb_rdata[`CTL_OVL_LSB +: 2] = q.overlay;
        end
        default: d.wb_rdata = 32'h0;
      endcase
      if (wb_we_i && wb_sel_i[0]) begin
        if (wb_adr_i == `REG_CONTROL_OFS) begin
          d.ecc2_en = wb_dat_i[`CTL_ECC2_BIT];
          d.overlay = flash_seq_pkg::address_overlay_type'(wb_dat_i[`CTL_OVL_LSB +: 2]);
        end
        // clear comes first so that a same-cycle abort below still sets
        if (wb_adr_i == `REG_COMMAND_OFS && wb_dat_i[`CMD_CLEAR_BIT]) begin
          d.pgm_fail    = 1'b0;
          d.buf_abort   = 1'b0;
          d.locked_fail = 1'b0;
        end
      end
    end

    // command sequencer
    case (q.state)
      flash_seq_pkg::ST_IDLE: begin
        if (wv) begin
          if (q.overlay == flash_seq_pkg::OV_MAIN ||
              q.overlay == flash_seq_pkg::OV_SECURE) begin
            // first unlock, main or secure only
            if (wa[11:0] == `UNLOCK1_ADDR && wd[7:0] == `UNLOCK1_DATA) begin
              d.state = flash_seq_pkg::ST_UNLOCK1;
            end
          end else if (wd == WORD_PGM_CODE) begin
            d.state       = flash_seq_pkg::ST_WP_SETUP;
            d.volatile_op = (q.overlay == flash_seq_pkg::OV_VOLATILE);
            d.wp_cnt      = 9'h0;
            d.loaded      = '0;
          end
        end
      end
      flash_seq_pkg::ST_UNLOCK1: begin
        if (wv) begin
          if (wa[11:0] == `UNLOCK2_ADDR && wd[7:0] == `UNLOCK2_DATA) begin
            d.state = flash_seq_pkg::ST_UNLOCK2;
          end else begin
            d.state = flash_seq_pkg::ST_IDLE;
          end
        end
      end
      flash_seq_pkg::ST_UNLOCK2: begin
        if (wv) begin
          d.state       = flash_seq_pkg::ST_IDLE;
          d.volatile_op = 1'b0;
          d.loaded      = '0;
          d.erase_ret   = erase_suspended_i;
          if (wd == WORD_PGM_CODE) begin
            d.state  = flash_seq_pkg::ST_WP_SETUP;
            d.wp_cnt = 9'h0;
          end else if (wd == `BUF_LOAD_CODE) begin
            d.state  = flash_seq_pkg::ST_BUF_COUNT;
            d.sector = wa[31:17];
          end
        end
      end
      flash_seq_pkg::ST_WP_SETUP: begin
        if (wv) begin
          d.wp_cnt = q.wp_cnt + 9'h1;
          if (q.wp_cnt == 9'h0) begin
            d.start_addr = wa;
            d.sector     = wa[31:17];
          end else if (wa[7:0] == 8'h00) begin
            d.state    = flash_seq_pkg::ST_IDLE;
            d.pgm_fail = 1'b1;
          end
        end else if (q.burst_end && q.wp_cnt != 9'h0) begin
          if (sector_protected_i && !q.volatile_op) begin
            d.state       = flash_seq_pkg::ST_IDLE;
            d.pgm_fail    = 1'b1;
            d.locked_fail = 1'b1;
          end else begin
            d.state = flash_seq_pkg::ST_BUSY;
            d.start = 1'b1;
            d.count = q.wp_cnt[7:0] - 8'h1;
          end
        end
      end
      flash_seq_pkg::ST_BUF_COUNT: begin
        if (wv) begin
          // sector must match, count at most 255
          if (!sec_match || wd > `BUF_COUNT_MAX) begin
            d.state     = flash_seq_pkg::ST_IDLE;
            d.pgm_fail  = 1'b1;
            d.buf_abort = 1'b1;
          end else begin
            d.state = flash_seq_pkg::ST_BUF_LOAD;
            d.count = wd[7:0];
            d.left  = wd[7:0];
            d.first = 1'b1;
          end
        end
      end
      flash_seq_pkg::ST_BUF_LOAD: begin
        if (wv) begin
          d.first = 1'b0;
          if (q.first) begin
            d.line       = wa[31:8];
            d.start_addr = wa;
          end
          if ((q.first && !sec_match) || (!q.first && wa[31:8] != q.line)) begin
            d.state     = flash_seq_pkg::ST_IDLE;
            d.pgm_fail  = 1'b1;
            d.buf_abort = 1'b1;
          end else if (q.left == 8'h00) begin
            d.state = flash_seq_pkg::ST_BUF_CONFIRM;
          end else begin
            d.left = q.left - 8'h1;
          end
        end
      end
      flash_seq_pkg::ST_BUF_CONFIRM: begin
        if (wv) begin
          d.state = flash_seq_pkg::ST_IDLE;
          if (wd != `BUF_CONFIRM_CODE || !sec_match) begin
            d.pgm_fail  = 1'b1;
            d.buf_abort = 1'b1;
          end else if (sector_protected_i) begin
            d.pgm_fail    = 1'b1;
            d.locked_fail = 1'b1;
          end else begin
            d.state = flash_seq_pkg::ST_BUSY;
            d.start = 1'b1;
          end
        end
      end
      flash_seq_pkg::ST_BUSY: begin
        if (wv && wd == SUSPEND_CODE && q.overlay == flash_seq_pkg::OV_MAIN) begin
          d.state   = flash_seq_pkg::ST_SUSPENDED;
          d.suspend = 1'b1;
        end
        if (half_page_written_i) begin
          if (q.ecc2_en) begin
            // second program in a page is an error
            d.state    = flash_seq_pkg::ST_IDLE;
            d.abort    = 1'b1;
            d.pgm_fail = 1'b1;
          end else begin
            d.ecc_off = 1'b1;
          end
        end else if (pgm_done_i) begin
          d.state = flash_seq_pkg::ST_IDLE;
          if (pgm_fail_i) begin
            d.pgm_fail = 1'b1;
          end else begin
            d.pgm_fail    = 1'b0;
            d.buf_abort   = 1'b0;
            d.locked_fail = 1'b0;
          end
        end
      end
      flash_seq_pkg::ST_SUSPENDED: begin
        if (wv && wd == RESUME_CODE) begin
          d.state  = flash_seq_pkg::ST_BUSY;
          d.resume = 1'b1;
        end
      end
      flash_seq_pkg::ST_RECOVER: begin
        d.recover_cnt = q.recover_cnt - 12'h1;
        if (q.recover_cnt == 12'h1) begin
          d.state = flash_seq_pkg::ST_IDLE;
        end
      end
      default: d.state = flash_seq_pkg::ST_IDLE;
    endcase

    // hardware reset pin overrides the sequence
    if (!q.rst_sync[1]) begin
      d.state       = flash_seq_pkg::ST_RECOVER;
      d.recover_cnt = RECOVERY_LOAD;
      d.abort       = busy_like;
      d.start       = 1'b0;
    end

    // buffer read port, unloaded words read erased
    // buffer memory not preset; loaded bits select it
    d.rd_data = q.loaded[buf_rd_idx_i] ? buf_mem[buf_rd_idx_i] : `ERASED_WORD;
    if (buf_we) begin
      d.loaded[wa[7:0]] = 1'b1;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.ck_sync  <= 3'h0;
      q.cs_sync  <= 2'h3;
      q.rst_sync <= 2'h3;
      q.state    <= flash_seq_pkg::ST_IDLE;
      q.overlay  <= flash_seq_pkg::OV_MAIN;
    end else begin
      q <= d;
    end
  end

  // buffer storage kept out of reset; validity bits mask it
  always_ff @(posedge clk_i) begin
    if (buf_we) begin
      buf_mem[wa[7:0]] <= wd;
    end
  end

  // ****************************************
  // outputs straight from flip-flops
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ready_o <= 1'b1;
    end else begin
      ready_o <= !((d.state == flash_seq_pkg::ST_BUSY) ||
                   (d.state == flash_seq_pkg::ST_SUSPENDED) ||
                   (d.state == flash_seq_pkg::ST_RECOVER));
    end
  end

  assign wb_dat_o       = q.wb_rdata;
  assign wb_ack_o       = q.ack;
  assign buf_rd_data_o  = q.rd_data;
  assign sector_query_o = q.sector;
  assign pgm_start_o    = q.start;
  assign pgm_suspend_o  = q.suspend;
  assign pgm_resume_o   = q.resume;
  assign pgm_abort_o    = q.abort;
  assign pgm_volatile_o = q.volatile_op;
  assign pgm_addr_o     = q.start_addr;
  assign pgm_count_o    = q.count;
  assign ecc_disable_o  = q.ecc_off;

endmodule : flash_program_command_sequencer

// [dv/flash_program_command_sequencer_asserts.sv]
/*
  Port checker of the program command sequencer.
  Assumes it is bound to the top module and reads its ports only.
*/
`timescale 1ns/10ps
module flash_program_command_sequencer_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic pgm_done_i,
  input wire logic half_page_written_i,
  input wire logic pgm_start_o,
  input wire logic pgm_abort_o,
  input wire logic ecc_disable_o,
  input wire logic ready_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ****************************************
  // bus answer and reset
  // ****************************************
  property p_ack; (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus ack late");
  property p_ack_drop; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("bus ack held");
  // reset is checked while it is high, so it cannot disable itself
  property p_rst; disable iff (1'b0) rst_i |=> (ready_o && !wb_ack_o && !pgm_start_o);
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not quiet in reset");

  // ****************************************
  // programming flow
  // ****************************************
  property p_start_pulse; pgm_start_o |=> !pgm_start_o; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");
  property p_busy; pgm_start_o |=> !ready_o [*2]; endproperty
  a_busy: assert property (p_busy) else $error("ready during program");  // busy shown
  property p_ignore; (!ready_o && $past(!ready_o)) |-> !pgm_start_o; endproperty
  a_ignore: assert property (p_ignore) else $error("start while busy");  // busy ignores
  property p_done; (pgm_done_i && !ready_o && reset_n_i) |-> ##[1:3] ready_o; endproperty
  a_done: assert property (p_done) else $error("no standby after done");  // back to standby
  property p_hw; $fell(reset_n_i) |-> ##[1:4] !ready_o; endproperty
  a_hw: assert property (p_hw) else $error("reset pin ignored");  // reset pin
  property p_hw_abort; ($fell(reset_n_i) && !ready_o) |-> ##[1:4] pgm_abort_o; endproperty
  a_hw_abort: assert property (p_hw_abort) else $error("program not aborted");  // abort
  property p_ecc;
    (half_page_written_i && !ready_o) |-> ##[1:4] (ecc_disable_o || pgm_abort_o); endproperty
  a_ecc: assert property (p_ecc) else $error("ecc left on");  // ecc off

  c_start: cover property (pgm_start_o);
  c_abort: cover property (pgm_abort_o);
  c_ecc: cover property (ecc_disable_o);
endmodule : flash_program_command_sequencer_asserts

bind flash_program_command_sequencer flash_program_command_sequencer_asserts
  flash_program_command_sequencer_asserts_i (.*);

// [dv/link_host_model.sv]
/*
  Host memory controller model: sends command write frames on the link.
  Assumes clk_i is the block clock; four clk_i cycles make one ck half period.
*/
`timescale 1ns/10ps
module link_host_model (
  input  wire logic       clk_i,
  output logic            ck_o,
  output logic            cs_n_o,
  output logic [7:0]      dq_o
);
  // link clock stands low outside frames
  initial begin
    ck_o = 1'b0;
    cs_n_o = 1'b1;
    dq_o = 8'h00;
  end

  // data settles two cycles before its ck edge and holds two after
  task automatic put_byte(input logic [7:0] b);
    dq_o <= b;
    repeat (2) @(posedge clk_i);
    ck_o <= ~ck_o;
    repeat (2) @(posedge clk_i);
  endtask : put_byte

  // one write frame: address phase, then n words at rising addresses
  task automatic frame(input logic [31:0] a, input logic [15:0] d0, input int n);
    logic [47:0] ca;
    logic [15:0] w;
    ca = {3'b000, a[31:3], 13'h0000, a[2:0]};
    cs_n_o <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 6; i++) put_byte(ca[47 - 8 * i -: 8]);
    for (int i = 0; i < n; i++) begin
      w = d0 + 16'(i);
      put_byte(w[15:8]);
      put_byte(w[7:0]);
    end
    // released bus shows no stale data
    cs_n_o <= 1'b1;
    dq_o <= ~dq_o;
    repeat (6) @(posedge clk_i);
  endtask : frame
endmodule : link_host_model

// [dv/flash_program_command_sequencer_test.sv]
/*
  Self-checking bench of the program command sequencer.
  Assumes the link host model drives the link and the bench plays the engine.
*/
`timescale 1ns/10ps
module flash_program_command_sequencer_test;
  localparam logic [31:0] SA  = 32'h0002_0000;
  localparam logic [15:0] WPC = 16'h00A0;
  logic        clk_i = 1'b0, rst_i = 1'b1, reset_n_i = 1'b1, ck_i, cs_n_i;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic        sector_protected_i = 1'b0, erase_suspended_i = 1'b0, pgm_fail_i = 1'b0;
  logic        pgm_done_i = 1'b0, half_page_written_i = 1'b0, ready_o, ecc_disable_o;
  logic        pgm_start_o, pgm_suspend_o, pgm_resume_o, pgm_abort_o, pgm_volatile_o, s_vol;
  logic [7:0]  dq_i, wb_adr_i = 8'h00, buf_rd_idx_i = 8'h00, pgm_count_o, s_cnt;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [14:0] sector_query_o;
  logic [15:0] buf_rd_data_o;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, pgm_addr_o, s_addr, rdat;
  int          fails = 0, n_checks = 0, n_start = 0, n_abort = 0, n_ecc = 0;

  flash_program_command_sequencer #(.WORD_PGM_CODE(WPC), .RECOVERY_NS(20))
    flash_program_command_sequencer_i (.*);
  link_host_model link_host_model_i (.clk_i(clk_i), .ck_o(ck_i), .cs_n_o(cs_n_i), .dq_o(dq_i));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // ****************************************
  // monitors and shared tasks
  // ****************************************
  // pulses are counted here so no scenario can miss one
  always @(posedge clk_i) begin
    if (pgm_start_o === 1'b1) begin
      n_start++;
      s_addr = pgm_addr_o;
      s_cnt = pgm_count_o;
      s_vol = pgm_volatile_o;
    end
    if (pgm_abort_o === 1'b1) n_abort++;
    if (ecc_disable_o === 1'b1) n_ecc++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'h1;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    chk(wb_ack_o, 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic st(input logic [7:0] e);
    wb(1'b0, 8'h00, 32'h0);
    chk(rdat, {24'h0, e});
  endtask : st

  task automatic send(input logic [31:0] a, input logic [15:0] d, input int n);
    link_host_model_i.frame(a, d, n);
  endtask : send

  task automatic unlock();
    send(32'h555, 16'h00AA, 1);
    send(32'h2AA, 16'h0055, 1);
  endtask : unlock

  task automatic wait_rdy(input logic v);
    int k = 0;
    while (ready_o !== v && k < 80) begin
      @(posedge clk_i);
      k++;
    end
    @(posedge clk_i);
    chk(ready_o, v);
  endtask : wait_rdy

  task automatic finish_pgm();
    pgm_done_i <= 1'b1;
    @(posedge clk_i);
    pgm_done_i <= 1'b0;
    wait_rdy(1'b1);
  endtask : finish_pgm

  // one word buffer sequence closed by the given confirm word
  task automatic buf1(input logic [15:0] cfm);
    unlock();
    send(SA, 16'h0025, 1);
    send(SA, 16'h0000, 1);
    send(SA + 32'h5, 16'h00AB, 1);
    send(SA, cfm, 1);
    repeat (10) @(posedge clk_i);
  endtask : buf1

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_buf_ok();
    int s;
    s = n_start;
    erase_suspended_i <= 1'b1;
    unlock();
    send(SA + 32'h33, 16'h0025, 1);
    erase_suspended_i <= 1'b0;
    send(SA + 32'h100, 16'h0007, 1);
    send(SA + 32'h10, 16'h1200, 8);
    send(SA, 16'h0029, 1);
    wait_rdy(1'b0);
    chk(n_start - s, 1);
    chk(s_addr, SA + 32'h10);
    chk(s_cnt, 8'h07);
    st(8'h40);
    buf_rd_idx_i <= 8'h12;
    repeat (2) @(posedge clk_i);
    chk(buf_rd_data_o, 16'h1202);
    buf_rd_idx_i <= 8'h20;
    repeat (2) @(posedge clk_i);
    chk(buf_rd_data_o, 16'hFFFF);
    unlock();
    send(SA, 16'h0025, 1);
    chk(n_start - s, 1);
    finish_pgm();
    st(8'hC0);
  endtask : t_buf_ok

  task automatic t_abort(input int k);
    int s;
    s = n_start;
    if (k == 3) buf1(16'h0028);
    else begin
      unlock();
      send(SA, 16'h0025, 1);
      case (k)
        0: send(SA, 16'h0100, 1);
        1: send(SA + 32'h0002_0000, 16'h0000, 1);
        default: begin
          send(SA, 16'h0001, 1);
          send(SA + 32'hFF, 16'h7700, 2);
        end
      endcase
      repeat (10) @(posedge clk_i);
    end
    chk(n_start - s, 0);
    st(8'h98);
    wb(1'b1, 8'h08, 32'h1);
    st(8'h80);
  endtask : t_abort

  task automatic t_word();
    int s, e;
    s = n_start;
    e = n_ecc;
    unlock();
    send(32'h555, WPC, 1);
    send(SA + 32'h40, 16'h5A00, 3);
    wait_rdy(1'b0);
    chk(n_start - s, 1);
    chk(s_addr, SA + 32'h40);
    chk(s_cnt, 8'h02);
    half_page_written_i <= 1'b1;
    @(posedge clk_i);
    half_page_written_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    chk(n_ecc - e, 1);
    finish_pgm();
  endtask : t_word

  task automatic t_protect();
    int s;
    s = n_start;
    sector_protected_i <= 1'b1;
    buf1(16'h0029);
    chk(n_start - s, 0);
    st(8'h92);
    sector_protected_i <= 1'b0;
    wb(1'b1, 8'h08, 32'h1);
    st(8'h80);
  endtask : t_protect

  task automatic t_overlay();
    int s;
    s = n_start;
    wb(1'b1, 8'h04, 32'h4);
    wb(1'b0, 8'h04, 32'h0);
    chk(rdat, 32'h4);
    buf1(16'h0029);
    chk(n_start - s, 0);
    wb(1'b1, 8'h04, 32'h6);
    send(SA, WPC, 1);
    send(SA + 32'h7, 16'h0F0F, 1);
    wait_rdy(1'b0);
    chk(n_start - s, 1);
    chk(s_vol, 1'b1);
    wb(1'b1, 8'h04, 32'h7);
    half_page_written_i <= 1'b1;
    @(posedge clk_i);
    half_page_written_i <= 1'b0;
    wait_rdy(1'b1);
    st(8'h90);
    wb(1'b1, 8'h04, 32'h0);
    wb(1'b1, 8'h08, 32'h1);
    wb(1'b0, 8'hFC, 32'h0);
    chk(rdat, 32'h0);
  endtask : t_overlay

  task automatic t_hwreset();
    int a;
    a = n_abort;
    unlock();
    send(32'h555, WPC, 1);
    send(SA + 32'h80, 16'h1234, 1);
    wait_rdy(1'b0);
    reset_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(n_abort - a, 1);
    chk(ready_o, 1'b0);
    reset_n_i <= 1'b1;
    wait_rdy(1'b1);
  endtask : t_hwreset

  task automatic close_out();
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  // watchdog: the whole run needs well under this many cycles
  initial begin
    repeat (30000) @(posedge clk_i);
    fails++;
    close_out();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_buf_ok();
    for (int k = 0; k < 4; k++) t_abort(k);
    t_word();
    t_protect();
    t_overlay();
    t_hwreset();
    close_out();
  end
endmodule : flash_program_command_sequencer_test
